// file: src/admcr_pkg.sv
// Shared constants and types for the audio processor main control register bank
package admcr_pkg;

  // ----------------------------------------------------------------------
  // Serial control port
  // ----------------------------------------------------------------------
  // Seven-bit bus address; the write byte on the wire is this shifted left
  localparam logic [6:0] DEV_ADDR = 7'h34;

  // ----------------------------------------------------------------------
  // Register subaddresses and reset values
  // ----------------------------------------------------------------------
  localparam logic [7:0] MC1_OFS = 8'h01;
  localparam logic [7:0] CODEC_OFS = 8'h40;
  localparam logic [7:0] MC2_OFS = 8'h43;
  localparam logic [7:0] MC1_RST = 8'h88;
  localparam logic [7:0] CODEC_RST = 8'h0f;
  localparam logic [7:0] MC2_RST = 8'h82;
  // Writable bits; reserved bits are not stored and read as zero
  localparam logic [7:0] MC2_WMASK = 8'h82;
  localparam logic [7:0] CODEC_WMASK = 8'hcf;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int MC1_FAST_BIT = 7;
  localparam int MC1_RATIO_BIT = 6;
  localparam int MC1_FMT_LSB = 4;
  localparam int MC1_LEN_LSB = 0;
  localparam int MC2_TONE_BIT = 7;
  localparam int MC2_BYP_BIT = 1;
  localparam int CODEC_MONO_BIT = 7;
  localparam int CODEC_SIDE_BIT = 6;
  localparam int CODEC_DEEMPH_LSB = 2;
  localparam int CODEC_SRC_BIT = 1;
  localparam int CODEC_PD_BIT = 0;

  // ----------------------------------------------------------------------
  // Field encodings
  // ----------------------------------------------------------------------
  localparam logic [1:0] FMT_LEFT = 2'h0;
  localparam logic [1:0] FMT_RIGHT = 2'h1;
  localparam logic [1:0] FMT_I2S = 2'h2;
  localparam logic [1:0] FMT_RSVD = 2'h3;
  localparam logic [1:0] DEEMPH_RSVD = 2'h3;
  localparam logic [4:0] LEN_16 = 5'h10;
  localparam logic [4:0] LEN_18 = 5'h12;
  localparam logic [4:0] LEN_20 = 5'h14;
  localparam logic [4:0] LEN_24 = 5'h18;

  // ----------------------------------------------------------------------
  // Serial port slave states
  // ----------------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_IDLE,
    ST_ADDR,
    ST_RX,
    ST_ACK_PRE,
    ST_ACK_ON,
    ST_TX,
    ST_RACK_REL,
    ST_RACK_SMP,
    ST_RACK_NXT
  } admcr_slv_state_e;

endpackage

// file: src/admcr_i2c_slave.sv
// Byte-level two-wire serial slave feeding the control register bank
`timescale 1ns/1ps
module admcr_i2c_slave (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  input wire logic [7:0] rd_data_i,
  output logic wr_valid_o,
  output logic [7:0] wr_data_o,
  output logic wr_first_o
);

  typedef struct packed {
    logic [1:0] scl_sync;
    logic [1:0] sda_sync;
    logic scl_p;
    logic sda_p;
    admcr_pkg::admcr_slv_state_e st;
    logic [2:0] cnt;
    logic [7:0] sh;
    logic rw;
    logic first;
    logic oe;
    logic wr_v;
    logic [7:0] wr_d;
    logic wr_f;
  } admcr_slv_s;

  admcr_slv_s q;
  admcr_slv_s d;
  logic scl;
  logic sda;
  logic rise;
  logic fall;
  logic start;
  logic stop;

  // --------------------------------------------------------------------
  // Line conditions
  // --------------------------------------------------------------------
  // Only the second synchroniser stage is looked at
  assign scl = q.scl_sync[1];
  assign sda = q.sda_sync[1];
  assign rise = scl & ~q.scl_p;
  assign fall = ~scl & q.scl_p;
  assign start = scl & q.scl_p & q.sda_p & ~sda;
  assign stop = scl & q.scl_p & ~q.sda_p & sda;

  // --------------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------------
  // Data is driven after the clock falls so it is stable through the high phase
  always_comb begin
    d = q;
    d.scl_sync = {q.scl_sync[0], scl_i};
    d.sda_sync = {q.sda_sync[0], sda_i};
    d.scl_p = scl;
    d.sda_p = sda;
    d.wr_v = 1'b0;
    if (start) begin
      d.st = admcr_pkg::ST_ADDR;
      d.cnt = 3'h0;
      d.oe = 1'b0;
    end else if (stop) begin
      d.st = admcr_pkg::ST_IDLE;
      d.oe = 1'b0;
    end else begin
      case (q.st)
        admcr_pkg::ST_ADDR, admcr_pkg::ST_RX: begin
          if (rise) begin
            d.sh = {q.sh[6:0], sda};
            d.cnt = q.cnt + 3'h1;
            if (q.cnt == 3'h7) begin
              if (q.st == admcr_pkg::ST_ADDR) begin
                if (q.sh[6:0] == admcr_pkg::DEV_ADDR) begin
                  d.rw = sda;
                  d.first = 1'b1;
                  d.st = admcr_pkg::ST_ACK_PRE;
                end else begin
                  d.st = admcr_pkg::ST_IDLE; // Not ours, stay off the bus
                end
              end else begin
                d.wr_v = 1'b1;
                d.wr_d = {q.sh[6:0], sda};
                d.wr_f = q.first;
                d.first = 1'b0;
                d.st = admcr_pkg::ST_ACK_PRE;
              end
            end
          end
        end
        admcr_pkg::ST_ACK_PRE: begin
          if (fall) begin
            d.oe = 1'b1;
            d.st = admcr_pkg::ST_ACK_ON;
          end
        end
        admcr_pkg::ST_ACK_ON: begin
          if (fall) begin
            d.cnt = 3'h0;
            if (q.rw) begin
              d.sh = rd_data_i;
              d.oe = ~rd_data_i[7];
              d.st = admcr_pkg::ST_TX;
            end else begin
              d.oe = 1'b0;
              d.st = admcr_pkg::ST_RX;
            end
          end
        end
        admcr_pkg::ST_TX: begin
          if (rise) begin
            d.cnt = q.cnt + 3'h1;
            if (q.cnt == 3'h7) begin
              d.st = admcr_pkg::ST_RACK_REL;
            end
          end else if (fall) begin
            d.sh = {q.sh[6:0], 1'b0};
            d.oe = ~q.sh[6];
          end
        end
        admcr_pkg::ST_RACK_REL: begin
          if (fall) begin
            d.oe = 1'b0;
            d.st = admcr_pkg::ST_RACK_SMP;
          end
        end
        admcr_pkg::ST_RACK_SMP: begin
          if (rise) begin
            d.st = sda ? admcr_pkg::ST_IDLE : admcr_pkg::ST_RACK_NXT;
          end
        end
        admcr_pkg::ST_RACK_NXT: begin
          if (fall) begin
            d.sh = rd_data_i;
            d.oe = ~rd_data_i[7];
            d.cnt = 3'h0;
            d.st = admcr_pkg::ST_TX;
          end
        end
        default: begin
          d.oe = 1'b0;
        end
      endcase
    end
  end

  // --------------------------------------------------------------------
  // State register
  // --------------------------------------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign sda_o = 1'b0; // Open drain: only ever pulls low
  assign sda_oe_o = q.oe;
  assign wr_valid_o = q.wr_v;
  assign wr_data_o = q.wr_d;
  assign wr_first_o = q.wr_f;

endmodule

// file: src/admcr_top.sv
// Main control and analog control register bank with its serial control port
`timescale 1ns/1ps
// Behaviour
// - Main control one bit 7 selects fast load; resets to one.
// - Bit 6 picks bit clock 32 or 64 fS; host keeps bit3=1, bit2=0.
// - Bits 5:4 audio format, bits 1:0 word length 16/18/20/24.
// - Main control two bit 7 selects downloaded bass and treble values.
// - Main control two bit 1 forces all equalizer filters to all-pass.
// - Main control two resets with bits 7 and 1 set; rest reserved.
// - Codec control bit 7 makes ADC output mono from B inputs.
// - In mono mode codec bit 6 picks B left (0) or B right (1).
// - Codec bits 3:2 de-emphasis: off, 48 kHz, 44.1 kHz, reserved.
// - Codec bit 1 selects A inputs when clear, B inputs when set.
// - Codec bit 0 set powers down the analog section.
// - Codec control resets to 0x0f: powered down, B inputs selected.
module admcr_top (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  output logic fast_load_o,
  output logic bitclk_ratio_o,
  output logic [1:0] serial_fmt_o,
  output logic [1:0] word_len_o,
  output logic [4:0] word_bits_o,
  output logic tone_source_sel_o,
  output logic eq_bypass_o,
  output logic adc_mono_enable_o,
  output logic mono_side_select_o,
  output logic mono_right_o,
  output logic [1:0] deemph_sel_o,
  output logic analog_source_sel_o,
  output logic analog_powerdown_o
);

  // --------------------------------------------------------------------
  // Register state
  // --------------------------------------------------------------------
  // All bank state lives in one packed struct so that reset and update
  // stay in one place; the serial slave keeps its own bit-level state.
  typedef struct packed {
    // Main control one, stored exactly as the host wrote it
    logic [7:0] mc1;
    // Codec input control; reserved bits 5:4 are never stored
    logic [7:0] codec;
    // Main control two; only bits 7 and 1 are stored
    logic [7:0] mc2;
    // Subaddress taken from the first byte after the bus address
    logic [7:0] sub;
    // Set once the single data byte of a transaction has landed
    logic wrote;
    // Decoded serial format; never shows the reserved code
    logic [1:0] fmt_eff;
    // Decoded de-emphasis; never shows the reserved code
    logic [1:0] deemph_eff;
  } admcr_regs_s;

  admcr_regs_s q;
  admcr_regs_s d;
  logic wr_valid;
  logic [7:0] wr_data;
  logic wr_first;
  logic [7:0] rd_data;

  // --------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------
  // Word length code to bit count
  function automatic logic [4:0] admcr_len_bits(input logic [1:0] code);
    logic [4:0] bits;
    case (code)
      2'h0: bits = admcr_pkg::LEN_16;
      2'h1: bits = admcr_pkg::LEN_18;
      2'h2: bits = admcr_pkg::LEN_20;
      default: bits = admcr_pkg::LEN_24;
    endcase
    return bits;
  endfunction

  // Read mux; unmapped subaddresses read as zero
  function automatic logic [7:0] admcr_read(input admcr_regs_s r);
    logic [7:0] v;
    case (r.sub)
      admcr_pkg::MC1_OFS: v = r.mc1;
      admcr_pkg::CODEC_OFS: v = r.codec;
      admcr_pkg::MC2_OFS: v = r.mc2;
      default: v = 8'h00;
    endcase
    return v;
  endfunction

  // --------------------------------------------------------------------
  // Serial control port
  // --------------------------------------------------------------------
  admcr_i2c_slave u_slave (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .scl_i(scl_i),
    .sda_i(sda_i),
    .sda_o(sda_o),
    .sda_oe_o(sda_oe_o),
    .rd_data_i(rd_data),
    .wr_valid_o(wr_valid),
    .wr_data_o(wr_data),
    .wr_first_o(wr_first)
  );

  assign rd_data = admcr_read(q);

  // --------------------------------------------------------------------
  // Register update
  // --------------------------------------------------------------------
  // First byte after the address is the subaddress; one data byte follows
  // since every register here is one byte wide, further bytes are dropped
  // Trade-off: extra bytes are still acknowledged, so a host that streams a
  // longer block sees no error, but only the first data byte takes effect.
  // A read transaction also writes the subaddress, which is how the host
  // points the read mux before the repeated start.
  always_comb begin
    d = q;
    if (wr_valid) begin
      if (wr_first) begin
        d.sub = wr_data;
        d.wrote = 1'b0;
      end else if (!q.wrote) begin
        d.wrote = 1'b1;
        case (q.sub)
          admcr_pkg::MC1_OFS: begin
            // Stored as written; bits 3 and 2 are the host's to
            d.mc1 = wr_data;
            // A reserved format code keeps the last valid one
            if (wr_data[admcr_pkg::MC1_FMT_LSB +: 2] != admcr_pkg::FMT_RSVD) begin
              d.fmt_eff = wr_data[admcr_pkg::MC1_FMT_LSB +: 2];
            end
          end
          admcr_pkg::CODEC_OFS: begin
            d.codec = wr_data & admcr_pkg::CODEC_WMASK;
            if (wr_data[admcr_pkg::CODEC_DEEMPH_LSB +: 2] != admcr_pkg::DEEMPH_RSVD) begin
              d.deemph_eff = wr_data[admcr_pkg::CODEC_DEEMPH_LSB +: 2];
            end
          end
          admcr_pkg::MC2_OFS: begin
            d.mc2 = wr_data & admcr_pkg::MC2_WMASK;
          end
          default: begin
            d.wrote = 1'b1; // Unmapped: write is ignored
          end
        endcase
      end
    end
  end

  // --------------------------------------------------------------------
  // State register
  // --------------------------------------------------------------------
  // Reset value of the decoded de-emphasis is reserved, so it falls back to off
  // Reset is synchronous; the stored registers still read back their raw
  // reset values so the host sees what it would expect after power-up.
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      q.mc1 <= admcr_pkg::MC1_RST;
      q.codec <= admcr_pkg::CODEC_RST;
      q.mc2 <= admcr_pkg::MC2_RST;
      q.sub <= 8'h00;
      q.wrote <= 1'b0;
      q.fmt_eff <= admcr_pkg::MC1_RST[admcr_pkg::MC1_FMT_LSB +: 2];
      q.deemph_eff <= 2'h0;
    end else begin
      q <= d;
    end
  end

  // --------------------------------------------------------------------
  // Field outputs
  // --------------------------------------------------------------------
  // Every field is taken or decoded only from flops, so the datapath never sees a
  // glitch while a byte is being shifted in; a field only moves one clock
  // after the last data bit of its byte has been taken.
  // Limitation: the host must keep main control one bits 3 and 2 at their
  // required levels; they are not forced here.
  assign fast_load_o = q.mc1[admcr_pkg::MC1_FAST_BIT];
  assign bitclk_ratio_o = q.mc1[admcr_pkg::MC1_RATIO_BIT];
  assign serial_fmt_o = q.fmt_eff;
  assign word_len_o = q.mc1[admcr_pkg::MC1_LEN_LSB +: 2];
  assign word_bits_o = admcr_len_bits(q.mc1[admcr_pkg::MC1_LEN_LSB +: 2]);
  assign tone_source_sel_o = q.mc2[admcr_pkg::MC2_TONE_BIT];
  assign eq_bypass_o = q.mc2[admcr_pkg::MC2_BYP_BIT];
  assign adc_mono_enable_o = q.codec[admcr_pkg::CODEC_MONO_BIT];
  assign mono_side_select_o = q.codec[admcr_pkg::CODEC_SIDE_BIT];
  // Side only matters in mono mode
  assign mono_right_o = q.codec[admcr_pkg::CODEC_MONO_BIT] &
                        q.codec[admcr_pkg::CODEC_SIDE_BIT];
  assign deemph_sel_o = q.deemph_eff;
  assign analog_source_sel_o = q.codec[admcr_pkg::CODEC_SRC_BIT];
  assign analog_powerdown_o = q.codec[admcr_pkg::CODEC_PD_BIT];

endmodule

// file: tb/admcr_top_asserts.sv
// Property checker for the control register bank outputs
`timescale 1ns/1ps
module admcr_top_chk (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe_o,
  input wire logic fast_load_o,
  input wire logic bitclk_ratio_o,
  input wire logic [1:0] serial_fmt_o,
  input wire logic [1:0] word_len_o,
  input wire logic [4:0] word_bits_o,
  input wire logic tone_source_sel_o,
  input wire logic eq_bypass_o,
  input wire logic adc_mono_enable_o,
  input wire logic mono_side_select_o,
  input wire logic mono_right_o,
  input wire logic [1:0] deemph_sel_o,
  input wire logic analog_source_sel_o,
  input wire logic analog_powerdown_o
);
  // ----------------------------------------------------------------------
  // Single clock domain
  // ----------------------------------------------------------------------
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);

  // Decoded outputs must never show a reserved code
  AST_FMT_VALID: assert property (serial_fmt_o != 2'h3)
    else $error("serial format shows reserved code");
  AST_DEEMPH_VALID: assert property (deemph_sel_o != 2'h3)
    else $error("de-emphasis shows reserved code");
  AST_WORD_BITS: assert property (word_bits_o == ((word_len_o == 2'h3) ? 5'h18 :
    5'h10 + {2'h0, word_len_o, 1'b0})) else $error("word length decode wrong");
  AST_MONO_RIGHT: assert property (mono_right_o == (adc_mono_enable_o & mono_side_select_o))
    else $error("mono right select wrong");
  // Open-drain data line: the device may only ever pull low
  AST_SDA_PULL_LOW: assert property (sda_o == 1'b0)
    else $error("data line driven high");
  // Values seen at the first edge after reset release
  AST_RST_MC1: assert property ($fell(rst_i) |-> fast_load_o && serial_fmt_o == 2'h0)
    else $error("main control one reset value wrong");
  AST_RST_MC2: assert property ($fell(rst_i) |-> tone_source_sel_o && eq_bypass_o)
    else $error("main control two reset value wrong");
  AST_RST_CODEC: assert property ($fell(rst_i) |-> analog_powerdown_o &&
    analog_source_sel_o && !adc_mono_enable_o && !mono_side_select_o && deemph_sel_o == 2'h0)
    else $error("codec control reset value wrong");
  // Registers only load after a data bit is clocked in, never in a long low phase
  AST_HOLD_SCL_LOW: assert property (!scl_i [*8] |-> $stable({fast_load_o,
    word_len_o, eq_bypass_o, analog_powerdown_o, adc_mono_enable_o}))
    else $error("field changed with serial clock held low");
endmodule

bind admcr_top admcr_top_chk u_chk (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .scl_i(scl_i),
  .sda_i(sda_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o), .fast_load_o(fast_load_o),
  .bitclk_ratio_o(bitclk_ratio_o), .serial_fmt_o(serial_fmt_o), .word_len_o(word_len_o),
  .word_bits_o(word_bits_o), .tone_source_sel_o(tone_source_sel_o), .eq_bypass_o(eq_bypass_o),
  .adc_mono_enable_o(adc_mono_enable_o), .mono_side_select_o(mono_side_select_o),
  .mono_right_o(mono_right_o), .deemph_sel_o(deemph_sel_o),
  .analog_source_sel_o(analog_source_sel_o), .analog_powerdown_o(analog_powerdown_o));

// file: tb/admcr_host_model.sv
// Behavioural serial control host driving the two-wire port
`timescale 1ns/1ps
module admcr_host_model (
  input wire logic ref_clk_i,
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_oe_o
);
  // Half period of 10 clocks keeps well above the port's minimum of 6
  localparam int HALF = 10;
  logic s;
  initial begin
    scl_o = 1'b1;
    sda_oe_o = 1'b0;
  end
  task automatic tick();
    repeat (HALF) @(negedge ref_clk_i);
  endtask
  // Data moves only a few clocks after SCL falls, so it never looks like a start
  task automatic low();
    scl_o = 1'b0;
    repeat (3) @(negedge ref_clk_i);
  endtask
  task automatic clk_bit(input logic b);
    sda_oe_o = ~b;
    tick();
    scl_o = 1'b1;
    tick();
    s = sda_i;
    low();
  endtask
  task automatic start();
    sda_oe_o = 1'b0;
    tick();
    scl_o = 1'b1;
    tick();
    sda_oe_o = 1'b1;
    tick();
    low();
  endtask
  task automatic stop();
    sda_oe_o = 1'b1;
    tick();
    scl_o = 1'b1;
    tick();
    sda_oe_o = 1'b0;
    tick();
  endtask
  // Byte goes out most significant bit first; ninth pulse released for the ack
  task automatic put(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) clk_bit(b[i]);
    clk_bit(1'b1);
    ack = ~s;
  endtask
  task automatic wr(input logic [6:0] dev, input logic [7:0] sub, d, output logic [2:0] a);
    start();
    put({dev, 1'b0}, a[2]);
    put(sub, a[1]);
    put(d, a[0]);
    stop();
  endtask
  task automatic rd(input logic [7:0] sub, output logic [7:0] d);
    logic a;
    start();
    put({admcr_pkg::DEV_ADDR, 1'b0}, a);
    put(sub, a);
    start();
    put({admcr_pkg::DEV_ADDR, 1'b1}, a);
    for (int i = 7; i >= 0; i--) begin
      clk_bit(1'b1);
      d[i] = s;
    end
    clk_bit(1'b1);
    stop();
  endtask
endmodule

// file: tb/tb_audio_dsp_main_control_registers.sv
// Self-checking bench for the main control register bank
`timescale 1ns/1ps
module tb_audio_dsp_main_control_registers;
  logic ref_clk_i, rst_i, scl, host_oe, sda, sda_o, sda_oe_o, fast_load_o, bitclk_ratio_o;
  logic tone_source_sel_o, eq_bypass_o, adc_mono_enable_o, mono_side_select_o, mono_right_o;
  logic analog_source_sel_o, analog_powerdown_o;
  logic [1:0] serial_fmt_o, word_len_o, deemph_sel_o, dm;
  logic [4:0] word_bits_o;
  logic [7:0] rdat, d, e, mc1_v, mc2_v, codec_v;
  logic [2:0] acks;
  logic [7:0] tv [4] = '{8'h00, 8'hff, 8'h80, 8'h02};
  logic [7:0] cv [4] = '{8'h00, 8'hc5, 8'h8a, 8'h7e};
  int n_mismatch = 0;
  int checked = 0;
  int cyc = 0;
  // Open-drain wire with pull-up: low while anyone pulls
  assign sda = ~(host_oe | sda_oe_o);
  assign mc1_v = {fast_load_o, bitclk_ratio_o, serial_fmt_o, 2'h2, word_len_o};
  assign mc2_v = {tone_source_sel_o, 5'h0, eq_bypass_o, 1'b0};
  assign codec_v = {adc_mono_enable_o, mono_side_select_o, 2'h0, deemph_sel_o,
    analog_source_sel_o, analog_powerdown_o};
  admcr_top uut (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
    .sda_oe_o(sda_oe_o), .fast_load_o(fast_load_o), .bitclk_ratio_o(bitclk_ratio_o),
    .serial_fmt_o(serial_fmt_o), .word_len_o(word_len_o), .word_bits_o(word_bits_o),
    .tone_source_sel_o(tone_source_sel_o), .eq_bypass_o(eq_bypass_o),
    .adc_mono_enable_o(adc_mono_enable_o), .mono_side_select_o(mono_side_select_o),
    .mono_right_o(mono_right_o), .deemph_sel_o(deemph_sel_o),
    .analog_source_sel_o(analog_source_sel_o), .analog_powerdown_o(analog_powerdown_o));
  admcr_host_model host (.ref_clk_i(ref_clk_i), .sda_i(sda), .scl_o(scl), .sda_oe_o(host_oe));
  initial begin
    ref_clk_i = 1'b0;
    forever #4 ref_clk_i = ~ref_clk_i;
  end
  // Hang guard: the full run needs roughly half of this
  always @(posedge ref_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      n_mismatch++;
      $display("Error %0t: run did not finish", $time);
      wrap_up();
    end
  end
  task automatic chk(input logic [7:0] got, exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wrap_up();
    if (n_mismatch == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // Write expecting all three bytes acknowledged
  task automatic w(input logic [7:0] sub, dat);
    host.wr(admcr_pkg::DEV_ADDR, sub, dat, acks);
    chk({5'h0, acks}, 8'h07);
  endtask
  // Reset held for some clocks, then reset values on outputs and readback
  task automatic do_reset(input int n);
    @(negedge ref_clk_i);
    rst_i = 1'b1;
    repeat (n) @(negedge ref_clk_i);
    rst_i = 1'b0;
    repeat (4) @(negedge ref_clk_i);
    chk(mc1_v, 8'h88);
    chk(mc2_v, 8'h82);
    chk(codec_v, 8'h03);
    host.rd(admcr_pkg::MC1_OFS, rdat);
    chk(rdat, 8'h88);
    host.rd(admcr_pkg::MC2_OFS, rdat);
    chk(rdat, 8'h82);
    host.rd(admcr_pkg::CODEC_OFS, rdat);
    chk(rdat, 8'h0f);
  endtask
  initial begin
    rst_i = 1'b1;
    do_reset(10);
    // Every format and word length, keeping bit 3 set and bit 2 clear
    for (int i = 0; i < 4; i++) begin
      d = {i[0], i[1], 2'(i % 3), 2'h2, 2'(i)};
      w(admcr_pkg::MC1_OFS, d);
      chk(mc1_v, d);
      chk({3'h0, word_bits_o}, 8'(16 + 2 * i + ((i == 3) ? 2 : 0)));
    end
    // Reserved format is stored but the decoded format holds
    w(admcr_pkg::MC1_OFS, 8'hfb);
    chk(mc1_v, 8'hcb);
    host.rd(admcr_pkg::MC1_OFS, rdat);
    chk(rdat, 8'hfb);
    foreach (tv[k]) begin
      w(admcr_pkg::MC2_OFS, tv[k]);
      chk(mc2_v, tv[k] & 8'h82);
      host.rd(admcr_pkg::MC2_OFS, rdat);
      chk(rdat, tv[k] & 8'h82);
    end
    // Codec control: all de-emphasis codes, mono on both sides
    dm = 2'h0;
    foreach (cv[k]) begin
      w(admcr_pkg::CODEC_OFS, cv[k]);
      e = cv[k] & 8'hcf;
      if (e[3:2] != 2'h3) dm = e[3:2];
      chk(codec_v, {e[7:4], dm, e[1:0]});
      chk({7'h0, mono_right_o}, {7'h0, e[7] & e[6]});
      host.rd(admcr_pkg::CODEC_OFS, rdat);
      chk(rdat, e);
    end
    // Wrong bus address is not acknowledged and changes nothing
    host.wr(admcr_pkg::DEV_ADDR ^ 7'h01, admcr_pkg::MC1_OFS, 8'h08, acks);
    chk({5'h0, acks}, 8'h00);
    chk(mc1_v, 8'hcb);
    // Unmapped subaddress is acknowledged and reads zero
    w(8'h02, 8'h55);
    host.rd(8'h02, rdat);
    chk(rdat, 8'h00);
    do_reset(4);
    wrap_up();
  end
endmodule
